// ===== asmc_pkg.sv
// constants and types for the audio slot map register bank, channels 3 and 4
package asmc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus shape
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 2;

	////////////////////////////////////////////////////////////////////////////////
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] CH3_INDEX = 8'h0D;
	localparam logic [7:0] CH4_INDEX = 8'h0E;
	localparam logic [7:0] CH3_ADDR = 8'(CH3_INDEX * 4);
	localparam logic [7:0] CH4_ADDR = 8'(CH4_INDEX * 4);
	localparam logic [NUM_CH-1:0][7:0] REG_ADDR = {CH4_ADDR, CH3_ADDR};

	////////////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [7:0] CH3_RESET = 8'h02;
	localparam logic [7:0] CH4_RESET = 8'h03;
	localparam logic [NUM_CH-1:0][7:0] REG_RESET = {CH4_RESET, CH3_RESET};

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int RESERVED_BIT = 7;
	localparam int LINE_SEL_BIT = 6;
	localparam int SLOT_MSB = 5;
	localparam int HALF_BIT = 5;
	localparam int HALF_SLOT_MSB = 4;
	localparam logic [7:0] WRITABLE_MASK = 8'h7F;

	////////////////////////////////////////////////////////////////////////////////
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// route of one channel toward the serial framer
	typedef struct packed
	{
		logic line_sel;
		logic right_half;
		logic [5:0] slot;
	} asmc_route_t;

endpackage

// ===== asmc_slot_decode.sv
// slot field and line select decode of one channel
module asmc_slot_decode
(
	// configuration
	input wire logic [7:0] i_cfg,
	input wire logic i_tdm,
	// decoded route
	output asmc_pkg::asmc_route_t o_route
);

	wire logic line_sel;
	wire logic upper_half;
	wire logic [5:0] tdm_slot;
	wire logic [5:0] half_slot;

	assign line_sel = i_cfg[asmc_pkg::LINE_SEL_BIT];
	assign upper_half = i_cfg[asmc_pkg::HALF_BIT];
	// tdm keeps all six bits as the slot number
	assign tdm_slot = i_cfg[asmc_pkg::SLOT_MSB:0];
	// two-channel framing: bit 5 picks the right half, low bits the slot
	assign half_slot = {1'b0, i_cfg[asmc_pkg::HALF_SLOT_MSB:0]};

	assign o_route.line_sel = line_sel;
	assign o_route.right_half = i_tdm ? 1'b0 : upper_half;
	assign o_route.slot = i_tdm ? tdm_slot : half_slot;

endmodule

// ===== asmc_regs.sv
// slot map registers for channels 3 and 4 behind an axi4-lite slave
// Summary of operation
// - line select clear sends the channel word on the primary serial output
// - line select set sends the channel word on the secondary output pin
// - slot values 0..31: same slot in tdm, left slot of that number otherwise
// - slot values 32..63: same slot in tdm, right slot value minus 32 otherwise
// - channel 3 register at index 0x0D, resets to slot 2, primary output
// - channel 4 register at index 0x0E, resets to slot 3, primary output
module asmc_regs
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// framing mode from the serial framer
	input wire logic I_TDM_FRAMING,
	// write address channel
	input wire logic I_AWVALID,
	input wire logic [asmc_pkg::ADDR_W-1:0] I_AWADDR,
	output logic O_AWREADY,
	// write data channel
	input wire logic I_WVALID,
	input wire logic [asmc_pkg::DATA_W-1:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_WREADY,
	// write response channel
	output logic O_BVALID,
	output logic [1:0] O_BRESP,
	input wire logic I_BREADY,
	// read address channel
	input wire logic I_ARVALID,
	input wire logic [asmc_pkg::ADDR_W-1:0] I_ARADDR,
	output logic O_ARREADY,
	// read data channel
	output logic O_RVALID,
	output logic [asmc_pkg::DATA_W-1:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic I_RREADY,
	// routes toward the serial framer
	output asmc_pkg::asmc_route_t O_CH3_ROUTE,
	output asmc_pkg::asmc_route_t O_CH4_ROUTE
);

	////////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic [asmc_pkg::NUM_CH-1:0] reg_hit
	(
		input logic [asmc_pkg::ADDR_W-1:0] addr
	);
		logic [asmc_pkg::NUM_CH-1:0] hit;
		hit = '0;
		for (int i = 0; i < asmc_pkg::NUM_CH; i++)
		begin
			hit[i] = (addr[7:2] == asmc_pkg::REG_ADDR[i][7:2]);
		end
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// write channel state

	logic aw_held_reg;
	logic aw_held_next;
	logic [asmc_pkg::ADDR_W-1:0] aw_addr_reg;
	logic w_held_reg;
	logic w_held_next;
	logic [7:0] w_byte_reg;
	logic w_lane_reg;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic bvalid_next;
	logic [1:0] bresp_reg;

	wire logic aw_take;
	wire logic w_take;
	wire logic wr_fire;
	wire logic [asmc_pkg::NUM_CH-1:0] wr_hit;
	wire logic wr_mapped;

	assign aw_take = I_AWVALID && awready_reg;
	assign w_take = I_WVALID && wready_reg;
	// write only once both halves are held and the last response is gone
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wr_hit = reg_hit(aw_addr_reg);
	assign wr_mapped = |wr_hit;

	assign aw_held_next = wr_fire ? 1'b0 : (aw_held_reg || aw_take);
	assign w_held_next = wr_fire ? 1'b0 : (w_held_reg || w_take);
	assign bvalid_next = wr_fire ? 1'b1 : (bvalid_reg && !I_BREADY);

	always_ff @(posedge I_CLK or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
		end
		else
		begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awready_reg <= !aw_held_next;
			wready_reg <= !w_held_next;
			bvalid_reg <= bvalid_next;
		end
	end

	// payload flops carry no reset; they are only read while held
	always_ff @(posedge I_CLK)
	begin
		if (aw_take)
			aw_addr_reg <= I_AWADDR;
		if (w_take)
			w_byte_reg <= I_WDATA[7:0];
		if (w_take)
			w_lane_reg <= I_WSTRB[0];
	end

	always_ff @(posedge I_CLK or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
			bresp_reg <= asmc_pkg::RESP_OKAY;
		else if (wr_fire)
			bresp_reg <= wr_mapped ? asmc_pkg::RESP_OKAY : asmc_pkg::RESP_SLVERR;
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers and routes

	logic [7:0] cfg_reg [asmc_pkg::NUM_CH];
	asmc_pkg::asmc_route_t route_reg [asmc_pkg::NUM_CH];

	genvar g;
	generate
		for (g = 0; g < asmc_pkg::NUM_CH; g++)
		begin : gen_ch
			wire logic wr_en;
			wire logic [7:0] cfg_next;
			asmc_pkg::asmc_route_t route_next;

			// narrow register lives in lane 0 only
			assign wr_en = wr_fire && wr_hit[g] && w_lane_reg;
			// reserved bit never stored
			assign cfg_next = w_byte_reg & asmc_pkg::WRITABLE_MASK;

			always_ff @(posedge I_CLK or posedge I_SYS_RST)
			begin
				if (I_SYS_RST)
					cfg_reg[g] <= asmc_pkg::REG_RESET[g];
				else if (wr_en)
					cfg_reg[g] <= cfg_next;
			end

			asmc_slot_decode u_decode
			(
				.i_cfg(cfg_reg[g]),
				.i_tdm(I_TDM_FRAMING),
				.o_route(route_next)
			);

			// framer sees the route one cycle after the register changes
			always_ff @(posedge I_CLK or posedge I_SYS_RST)
			begin
				if (I_SYS_RST)
					route_reg[g] <= '0;
				else
					route_reg[g] <= route_next;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// read channel

	logic arready_reg;
	logic rvalid_reg;
	logic [7:0] rbyte_reg;
	logic [1:0] rresp_reg;

	wire logic ar_take;
	wire logic [asmc_pkg::NUM_CH-1:0] rd_hit;
	wire logic [7:0] rd_byte;

	assign ar_take = I_ARVALID && arready_reg;
	assign rd_hit = reg_hit(I_ARADDR);
	// one-hot select; reserved bit masked again so it always reads zero
	assign rd_byte = ((rd_hit[0] ? cfg_reg[0] : 8'h00)
		| (rd_hit[1] ? cfg_reg[1] : 8'h00)) & asmc_pkg::WRITABLE_MASK;

	always_ff @(posedge I_CLK or posedge I_SYS_RST)
	begin
		if (I_SYS_RST)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rbyte_reg <= 8'h00;
			rresp_reg <= asmc_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rbyte_reg <= rd_byte;
			rresp_reg <= (|rd_hit) ? asmc_pkg::RESP_OKAY : asmc_pkg::RESP_SLVERR;
		end
		else if (rvalid_reg && I_RREADY)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign O_AWREADY = awready_reg;
	assign O_WREADY = wready_reg;
	assign O_BVALID = bvalid_reg;
	assign O_BRESP = bresp_reg;
	assign O_ARREADY = arready_reg;
	assign O_RVALID = rvalid_reg;
	assign O_RDATA = {24'h00_0000, rbyte_reg};
	assign O_RRESP = rresp_reg;
	assign O_CH3_ROUTE = route_reg[0];
	assign O_CH4_ROUTE = route_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// checks

	a_primary_line: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!cfg_reg[0][asmc_pkg::LINE_SEL_BIT] ##1 !cfg_reg[0][asmc_pkg::LINE_SEL_BIT]
		|-> !O_CH3_ROUTE.line_sel)
		else $error("channel 3 left the primary line while select clear");

	a_secondary_line: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_SYS_RST && cfg_reg[1][asmc_pkg::LINE_SEL_BIT]) |=> O_CH4_ROUTE.line_sel)
		else $error("channel 4 not on secondary line while select set");

	// sampled reset in the antecedent: routes still read zero one edge after release
	a_ch3_secondary_line: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_SYS_RST && cfg_reg[0][asmc_pkg::LINE_SEL_BIT]) |=> O_CH3_ROUTE.line_sel)
		else $error("channel 3 not on secondary line while select set");

	a_left_half_slot: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_SYS_RST && !I_TDM_FRAMING && !cfg_reg[0][asmc_pkg::HALF_BIT])
		|=> !O_CH3_ROUTE.right_half
		&& O_CH3_ROUTE.slot == {1'b0, $past(cfg_reg[0][4:0])})
		else $error("low slot value not mapped to left half slot");

	a_right_half_slot: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_SYS_RST && !I_TDM_FRAMING && cfg_reg[1][asmc_pkg::HALF_BIT])
		|=> O_CH4_ROUTE.right_half
		&& O_CH4_ROUTE.slot == $past(cfg_reg[1][5:0]) - 6'h20)
		else $error("high slot value not mapped to right half minus 32");

	a_tdm_slot_same: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(!I_SYS_RST && I_TDM_FRAMING) |=> !O_CH3_ROUTE.right_half
		&& O_CH3_ROUTE.slot == $past(cfg_reg[0][5:0]))
		else $error("tdm slot differs from slot field");

	a_ch3_write_lands: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(wr_fire && aw_addr_reg == asmc_pkg::CH3_ADDR && w_lane_reg)
		|=> cfg_reg[0] == ($past(w_byte_reg) & 8'h7F) && O_BRESP == asmc_pkg::RESP_OKAY)
		else $error("write to channel 3 index not stored");

	a_ch4_write_lands: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(wr_fire && aw_addr_reg == asmc_pkg::CH4_ADDR && w_lane_reg)
		|=> cfg_reg[1] == ($past(w_byte_reg) & 8'h7F) && O_BRESP == asmc_pkg::RESP_OKAY)
		else $error("write to channel 4 index not stored");

	a_ch4_read_back: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(ar_take && I_ARADDR == asmc_pkg::CH4_ADDR)
		|=> O_RVALID && O_RDATA[7:0] == $past(cfg_reg[1]) && O_RRESP == asmc_pkg::RESP_OKAY)
		else $error("channel 4 read returned wrong value");

	a_ch3_read_back: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(ar_take && I_ARADDR == asmc_pkg::CH3_ADDR)
		|=> O_RVALID && O_RDATA[7:0] == $past(cfg_reg[0]) && O_RRESP == asmc_pkg::RESP_OKAY)
		else $error("channel 3 read returned wrong value");

	a_reserved_zero: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!cfg_reg[0][asmc_pkg::RESERVED_BIT] && !cfg_reg[1][asmc_pkg::RESERVED_BIT]
		&& !(O_RVALID && O_RDATA[asmc_pkg::RESERVED_BIT]))
		else $error("reserved bit seen set");

	a_write_answer: assert property (
		@(posedge I_CLK) disable iff (I_SYS_RST)
		wr_fire |=> O_BVALID && (O_BRESP == asmc_pkg::RESP_SLVERR) == !$past(wr_mapped))
		else $error("write response missing or wrong");

endmodule

// ===== asmc_host_model.sv
// audio host model: where each channel word lands on the serial side
module asmc_host_model
(
	// framing mode and routes from the slot map
	input wire logic i_tdm,
	input asmc_pkg::asmc_route_t [1:0] i_route,
	// landing place seen by the host
	output logic [1:0] o_on_primary,
	output logic [1:0] o_on_secondary,
	output logic [1:0][5:0] o_frame_pos
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	// left half is frame positions 0..31, right half 32..63
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			o_on_primary[c] = !i_route[c].line_sel;
			o_on_secondary[c] = i_route[c].line_sel;
			o_frame_pos[c] = i_tdm ? i_route[c].slot
				: {i_route[c].right_half, i_route[c].slot[4:0]};
		end
	end
endmodule

// ===== testbench.sv
// self-checking bench for the channel 3 and 4 slot map registers
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin n_mismatch++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); end end
	logic clk = 0, rst = 1, tdm = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, on_pri, on_sec;
	logic [31:0] rdata;
	asmc_pkg::asmc_route_t [1:0] route;
	logic [1:0][5:0] pos;
	logic [7:0] shadow [2];
	logic [7:0] addr_tab [3];
	int n_mismatch = 0, total_checks = 0;
	always #5 clk = ~clk;
	asmc_regs asmc_regs_inst(.I_CLK(clk), .I_SYS_RST(rst), .I_TDM_FRAMING(tdm),
		.I_AWVALID(awvalid), .I_AWADDR(awaddr), .O_AWREADY(awready), .I_WVALID(wvalid),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .O_WREADY(wready), .O_BVALID(bvalid),
		.O_BRESP(bresp), .I_BREADY(bready), .I_ARVALID(arvalid), .I_ARADDR(araddr),
		.O_ARREADY(arready), .O_RVALID(rvalid), .O_RDATA(rdata), .O_RRESP(rresp),
		.I_RREADY(rready), .O_CH3_ROUTE(route[0]), .O_CH4_ROUTE(route[1]));
	asmc_host_model asmc_host_model_inst(.i_tdm(tdm), .i_route(route),
		.o_on_primary(on_pri), .o_on_secondary(on_sec), .o_frame_pos(pos));
	////////////////////////////////////////////////////////////////////////////////
	// expectations
	function automatic asmc_pkg::asmc_route_t exp_route(input logic [7:0] f, input logic t);
		exp_route.line_sel = f[6];
		exp_route.right_half = t ? 1'b0 : f[5];
		exp_route.slot = t ? f[5:0] : {1'b0, f[4:0]};
	endfunction
	function automatic int chan_of(input logic [7:0] a);
		return a == 8'h34 ? 0 : a == 8'h38 ? 1 : -1;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// bus cycles; released address and data lines carry the inverse, not the old value; wstrb keeps it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic t);
		int c;
		logic aw, w;
		c = chan_of(a);
		aw = 1;
		w = 1;
		@(posedge clk);
		tdm <= t;
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= d;
		wstrb <= s;
		bready <= 1;
		while (aw || w)
		begin
			@(posedge clk);
			if (aw && awready)
			begin
				aw = 0;
				awvalid <= 0;
				awaddr <= ~a;
			end
			if (w && wready)
			begin
				w = 0;
				wvalid <= 0;
				wdata <= ~d;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 0;
		`CHK("bresp", c < 0 ? 2'h2 : 2'h0, bresp)
		if (c >= 0 && s[0])
			shadow[c] = d[7:0] & 8'h7F;
	endtask
	task automatic rd(input logic [7:0] a);
		int c;
		c = chan_of(a);
		@(posedge clk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do @(posedge clk); while (!arready);
		arvalid <= 0;
		araddr <= ~a;
		do @(posedge clk); while (!rvalid);
		rready <= 0;
		`CHK("rresp", c < 0 ? 2'h2 : 2'h0, rresp)
		`CHK("rdata", c < 0 ? 32'h0 : {24'h0, shadow[c]}, rdata)
	endtask
	task automatic chk_routes();
		@(posedge clk);
		#1;
		for (int c = 0; c < 2; c++)
		begin
			`CHK("route", exp_route(shadow[c], tdm), route[c])
			`CHK("line", {~shadow[c][6], shadow[c][6]}, {on_pri[c], on_sec[c]})
			`CHK("frame pos", shadow[c][5:0], pos[c])
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial
	begin
		#100000;
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		logic [7:0] v;
		void'($urandom(32'h85ac));
		shadow[0] = 8'h02;
		shadow[1] = 8'h03;
		addr_tab = '{8'h34, 8'h38, 8'h3C};
		repeat (5) @(posedge clk);
		rst <= 0;
		chk_routes();
		rd(8'h34);
		rd(8'h38);
		$display("test reset values done");
		// slot field boundaries, both lines, reserved bit set; slots 0 and 31 in two-channel framing, 32 and 63 in tdm
		for (int i = 0; i < 16; i++)
		begin
			v = i[1] ? (i[2] ? 8'h3F : 8'h20) : (i[2] ? 8'h1F : 8'h00);
			wr(i[0] ? 8'h38 : 8'h34, {24'hFF_FFFF, 1'b1, i[3], v[5:0]}, 4'hF, i[1]);
			chk_routes();
			rd(i[0] ? 8'h38 : 8'h34);
		end
		$display("test slot corners done");
		repeat (40)
		begin
			v = addr_tab[$urandom % 3];
			wr(v, $urandom, 4'($urandom), 1'($urandom));
			chk_routes();
			rd(v);
		end
		$display("test random traffic done");
		end_of_test();
	end
endmodule
